// [src/trim_cfg_pkg.sv]
// constants for the trim and configuration register bank
package trim_cfg_pkg;

	// register offsets on the internal register port
	localparam logic [7:0] OFS_SHARE_SLOPE = 8'h06;
	localparam logic [7:0] OFS_NVM_LOCK    = 8'h07;
	localparam logic [7:0] OFS_REMOTE_OVERVOLT_TRIM     = 8'h08;
	localparam logic [7:0] OFS_LOCAL_UV    = 8'h09;
	localparam logic [7:0] OFS_LOCAL_OV    = 8'h0a;
	localparam logic [7:0] OFS_OVERTEMP    = 8'h0b;
	localparam logic [7:0] OFS_MAINS_SENSE = 8'h0c;
	localparam logic [7:0] OFS_CONFIG_ONE  = 8'h0d;
	localparam int         NUM_REGS        = 8;

	// nonvolatile boot image of the bank
	localparam logic [15:0] NVM_BOOT_BASE = 16'h8106;

	// implemented bits per register, reserved bits read zero
	localparam logic [7:0] MASK_SHARE_SLOPE = 8'hfe;
	localparam logic [7:0] MASK_NVM_LOCK    = 8'h7f;
	localparam logic [7:0] MASK_FULL        = 8'hff;
	localparam logic [7:0] MASK_OVERTEMP    = 8'hf1;
	localparam logic [7:0] MASK_CONFIG_ONE  = 8'h9f;

	// value held before the boot copy completes
	localparam logic [7:0] CFG_RESET = 8'h00;

	// synchroniser state in reset, serial lines idle high
	localparam logic [7:0] PIN_SYNC_RESET = 8'h03;

	// field positions
	localparam int LOCK_REGION_A  = 0;
	localparam int LOCK_REGION_B  = 1;
	localparam int LOCK_REGION_C  = 2;
	localparam int LOCK_REGION_D  = 3;
	localparam int LOCK_BOOT      = 4;
	localparam int LOCK_FACTORY   = 5;
	localparam int LOCK_REGION_E  = 6;
	localparam int OT_SOFT_BIT    = 0;
	localparam int CFG_PSON_SRC   = 7;
	localparam int CFG_UVB_MODE   = 4;
	localparam int CFG_MON1_HI    = 3;
	localparam int CFG_MON1_LO    = 1;
	localparam int CFG_PIN_REMAP  = 0;

	// nonvolatile region bounds
	localparam logic [15:0] NVM_FIELD_LO   = 16'h8000;
	localparam logic [15:0] NVM_FIELD_HI   = 16'h80ff;
	localparam logic [15:0] NVM_BOOT_LO    = 16'h8100;
	localparam logic [15:0] NVM_BOOT_HI    = 16'h811f;
	localparam logic [15:0] NVM_FACTORY_LO = 16'h8120;
	localparam logic [15:0] NVM_FACTORY_HI = 16'h813f;
	localparam logic [15:0] NVM_FIELDE_LO  = 16'h8140;
	localparam logic [15:0] NVM_FIELDE_HI  = 16'h817f;

	// monitor-1 function codes
	typedef enum logic [2:0] {
		MON1_PASS_A  = 3'h0,
		MON1_PASS_B  = 3'h1,
		MON1_POS_OV  = 3'h2,
		MON1_POS_UV  = 3'h3,
		MON1_NEG_OV  = 3'h4,
		MON1_NEG_UV  = 3'h5,
		MON1_FLAG    = 3'h6,
		MON1_FLAG_N  = 3'h7
	} mon1_func_e;

	// boot copy sequencer
	typedef enum logic [1:0] {
		BOOT_IDLE  = 2'b00,
		BOOT_FETCH = 2'b01,
		BOOT_WAIT  = 2'b11,
		BOOT_DONE  = 2'b10
	} boot_state_e;

endpackage : trim_cfg_pkg

// [src/mon1_if.sv]
// carrier between the bank and the monitor-1 decoder
`timescale 1ns/100ps
interface mon1_if;
	logic [2:0] func_sel;
	logic       above_115;
	logic       above_125;
	logic       above_135;
	logic       sense_one;
	logic       flag;
	logic       ov;
	logic       uv;

	modport bank
	(
		output func_sel,
		output above_115,
		output above_125,
		output above_135,
		output sense_one,
		input  flag,
		input  ov,
		input  uv
	);

	modport decoder
	(
		input  func_sel,
		input  above_115,
		input  above_125,
		input  above_135,
		input  sense_one,
		output flag,
		output ov,
		output uv
	);
endinterface : mon1_if

// [src/mon1_decode.sv]
// monitor-1 function decoder with comparator hysteresis
`timescale 1ns/100ps
module mon1_decode
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic nrst,
	// bank side
	mon1_if.decoder   mon
);

	logic high_r;
	logic high_nxt;
	logic hi_cmp;
	logic lo_cmp;
	logic flag_nxt;
	logic ov_nxt;
	logic uv_nxt;

	// upper window 1.25/1.35 V for positive uv and negative ov
	always_comb
	begin
		if (mon.func_sel == trim_cfg_pkg::MON1_POS_UV ||
			mon.func_sel == trim_cfg_pkg::MON1_NEG_OV)
		begin
			lo_cmp = mon.above_125;
			hi_cmp = mon.above_135;
		end
		else
		begin
			lo_cmp = mon.above_115;
			hi_cmp = mon.above_125;
		end
		high_nxt = high_r;
		if (hi_cmp)
			high_nxt = 1'b1;
		else if (!lo_cmp)
			high_nxt = 1'b0;
	end

	always_comb
	begin
		flag_nxt = high_nxt;
		ov_nxt   = 1'b0;
		uv_nxt   = 1'b0;
		case (mon.func_sel)
			trim_cfg_pkg::MON1_POS_OV: ov_nxt = high_nxt;
			trim_cfg_pkg::MON1_POS_UV: uv_nxt = !high_nxt;
			trim_cfg_pkg::MON1_NEG_OV: ov_nxt = !high_nxt;
			trim_cfg_pkg::MON1_NEG_UV: uv_nxt = high_nxt;
			trim_cfg_pkg::MON1_FLAG:   flag_nxt = high_nxt;
			trim_cfg_pkg::MON1_FLAG_N: flag_nxt = !high_nxt;
			default:                   flag_nxt = mon.sense_one;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			high_r <= 1'b0;
		else
			high_r <= high_nxt;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mon.flag <= 1'b0;
			mon.ov   <= 1'b0;
			mon.uv   <= 1'b0;
		end
		else
		begin
			mon.flag <= flag_nxt;
			mon.ov   <= ov_nxt;
			mon.uv   <= uv_nxt;
		end
	end

endmodule : mon1_decode

// [src/psu_trim_config_registers.sv]
// trim and configuration register bank with boot copy and nvm locks
// Overview of operation
// - boot copies nonvolatile 8106h..810Dh into registers
// - share slope trim in bits 7..1
// - lock bits 0..3,6 protect field regions
// - lock bit 5 protects factory calibration
// - lock bit 4 protects boot image
// - three full 8-bit voltage trims
// - over-temperature threshold in bits 7..4
// - bit 0 routes monitor five overvoltage
// - mains sense threshold and hysteresis trims
// - monitor1 positive overvoltage mode
// - monitor1 positive undervoltage mode
// - monitor1 negative overvoltage mode
// - monitor1 negative undervoltage mode
// - monitor1 flag, inverted flag, sense passthrough
`timescale 1ns/100ps
module psu_trim_config_registers
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// register port from the serial engine
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	output logic             reg_hit,
	// nonvolatile read port for the boot copy
	output logic             nvm_rd_req,
	output logic [15:0]      nvm_rd_addr,
	input  wire logic        nvm_rd_valid,
	input  wire logic [7:0]  nvm_rd_data,
	output logic             boot_done,
	// host nonvolatile write or erase filter
	input  wire logic        host_nvm_req,
	input  wire logic [15:0] host_nvm_addr,
	output logic             nvm_wr_grant,
	output logic             nvm_wr_refused,
	// trim outputs to analog
	output logic [6:0]       share_slope_trim,
	output logic [7:0]       remote_overvolt_trim,
	output logic [7:0]       local_undervolt_trim,
	output logic [7:0]       local_overvolt_trim,
	output logic [3:0]       overtemp_trim,
	output logic [4:0]       mains_thresh_trim,
	output logic [2:0]       mains_hyst_trim,
	// monitor five overvoltage routing
	input  wire logic        monitor_five_ov_pin,
	output logic             monitor_five_ov,
	output logic             soft_overtemp,
	// power-on source
	input  wire logic        internal_pson,
	input  wire logic        sw_pson_bit,
	output logic             pson_selected,
	// blanking hold
	input  wire logic        mains_good_pin,
	output logic             blank_hold_start,
	// monitor 1
	input  wire logic        mon1_above_115_pin,
	input  wire logic        mon1_above_125_pin,
	input  wire logic        mon1_above_135_pin,
	input  wire logic        mains_sense_one_input,
	output logic             monitor1_flag,
	output logic             monitor1_ov,
	output logic             monitor1_uv,
	// serial pins
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// serial engine pin side
	input  wire logic        smb_scl_pull,
	input  wire logic        smb_sda_pull,
	output logic             smb_scl_in,
	output logic             smb_sda_in,
	// link outputs carried on remapped pins
	input  wire logic        mains_good_link,
	input  wire logic        pson_link
);

	localparam int NPIN = 8;

	logic [7:0]               cfg_r [trim_cfg_pkg::NUM_REGS];
	logic [7:0]               mask_t [trim_cfg_pkg::NUM_REGS];
	logic [NPIN-1:0]          sync1_r;
	logic [NPIN-1:0]          sync2_r;
	logic [NPIN-1:0]          pin_raw;
	logic                     scl_s;
	logic                     sda_s;
	logic                     mgood_s;
	logic                     m5ov_s;
	logic                     sense_s;
	logic                     a115_s;
	logic                     a125_s;
	logic                     a135_s;
	trim_cfg_pkg::boot_state_e state_r;
	trim_cfg_pkg::boot_state_e state_nxt;
	logic [2:0]               idx_r;
	logic [2:0]               idx_nxt;
	logic                     reg_in_range;
	logic [2:0]               reg_idx;
	logic                     host_wr_ok;
	logic [6:0]               lock;
	logic                     addr_locked;
	logic                     mgood_d_r;
	logic                     scl_d_r;
	logic                     remap;

	mon1_if mon ();

	// pin synchronisers
	assign pin_raw = {mon1_above_135_pin, mon1_above_125_pin,
		mon1_above_115_pin, mains_sense_one_input, monitor_five_ov_pin,
		mains_good_pin, sda_in, scl_in};

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_r <= trim_cfg_pkg::PIN_SYNC_RESET;
			sync2_r <= trim_cfg_pkg::PIN_SYNC_RESET;
		end
		else
		begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
		end
	end

	assign scl_s   = sync2_r[0];
	assign sda_s   = sync2_r[1];
	assign mgood_s = sync2_r[2];
	assign m5ov_s  = sync2_r[3];
	assign sense_s = sync2_r[4];
	assign a115_s  = sync2_r[5];
	assign a125_s  = sync2_r[6];
	assign a135_s  = sync2_r[7];

	// boot copy sequencer
	always_comb
	begin
		state_nxt = state_r;
		idx_nxt   = idx_r;
		case (state_r)
			trim_cfg_pkg::BOOT_IDLE:
				state_nxt = trim_cfg_pkg::BOOT_FETCH;
			trim_cfg_pkg::BOOT_FETCH:
				state_nxt = trim_cfg_pkg::BOOT_WAIT;
			trim_cfg_pkg::BOOT_WAIT:
			begin
				if (nvm_rd_valid)
				begin
					if (idx_r == 3'(trim_cfg_pkg::NUM_REGS - 1))
						state_nxt = trim_cfg_pkg::BOOT_DONE;
					else
					begin
						state_nxt = trim_cfg_pkg::BOOT_FETCH;
						idx_nxt   = idx_r + 3'h1;
					end
				end
			end
			trim_cfg_pkg::BOOT_DONE:
				state_nxt = trim_cfg_pkg::BOOT_DONE;
			default:
				state_nxt = trim_cfg_pkg::BOOT_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= trim_cfg_pkg::BOOT_IDLE;
			idx_r   <= 3'h0;
		end
		else
		begin
			state_r <= state_nxt;
			idx_r   <= idx_nxt;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			nvm_rd_req  <= 1'b0;
			nvm_rd_addr <= trim_cfg_pkg::NVM_BOOT_BASE;
		end
		else
		begin
			nvm_rd_req  <= (state_r == trim_cfg_pkg::BOOT_FETCH);
			nvm_rd_addr <= trim_cfg_pkg::NVM_BOOT_BASE + 16'(idx_r);
		end
	end

	assign boot_done = (state_r == trim_cfg_pkg::BOOT_DONE);

	// register file, one entry per offset
	assign mask_t[0] = trim_cfg_pkg::MASK_SHARE_SLOPE;
	assign mask_t[1] = trim_cfg_pkg::MASK_NVM_LOCK;
	assign mask_t[2] = trim_cfg_pkg::MASK_FULL;
	assign mask_t[3] = trim_cfg_pkg::MASK_FULL;
	assign mask_t[4] = trim_cfg_pkg::MASK_FULL;
	assign mask_t[5] = trim_cfg_pkg::MASK_OVERTEMP;
	assign mask_t[6] = trim_cfg_pkg::MASK_FULL;
	assign mask_t[7] = trim_cfg_pkg::MASK_CONFIG_ONE;

	assign reg_in_range = reg_addr >= trim_cfg_pkg::OFS_SHARE_SLOPE &&
		reg_addr <= trim_cfg_pkg::OFS_CONFIG_ONE;
	assign reg_idx    = 3'(reg_addr - trim_cfg_pkg::OFS_SHARE_SLOPE);
	assign host_wr_ok = reg_wr && reg_in_range && boot_done;

	genvar gi;
	generate
		for (gi = 0; gi < trim_cfg_pkg::NUM_REGS; gi++)
		begin : g_reg
			always_ff @(posedge sys_clk or negedge nrst)
			begin
				if (!nrst)
					cfg_r[gi] <= trim_cfg_pkg::CFG_RESET;
				else if (state_r == trim_cfg_pkg::BOOT_WAIT && nvm_rd_valid &&
					idx_r == 3'(gi))
					cfg_r[gi] <= nvm_rd_data & mask_t[gi];
				else if (host_wr_ok && reg_idx == 3'(gi))
					cfg_r[gi] <= reg_wdata & mask_t[gi];
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata <= 8'h00;
			reg_hit   <= 1'b0;
		end
		else
		begin
			reg_hit   <= (reg_rd || reg_wr) && reg_in_range;
			if (reg_rd && reg_in_range)
				reg_rdata <= cfg_r[reg_idx];
			else if (reg_rd)
				reg_rdata <= 8'h00;
		end
	end

	// trim fields
	assign share_slope_trim     = cfg_r[0][7:1];
	assign remote_overvolt_trim = cfg_r[2];
	assign local_undervolt_trim = cfg_r[3];
	assign local_overvolt_trim  = cfg_r[4];
	assign overtemp_trim        = cfg_r[5][7:4];
	assign mains_thresh_trim    = cfg_r[6][7:3];
	assign mains_hyst_trim      = cfg_r[6][2:0];

	// nonvolatile region locks
	assign lock  = cfg_r[1][6:0];
	always_comb
	begin
		addr_locked = 1'b0;
		if (host_nvm_addr >= trim_cfg_pkg::NVM_FIELD_LO &&
			host_nvm_addr <= trim_cfg_pkg::NVM_FIELD_HI)
			addr_locked = lock[host_nvm_addr[7:6]];
		else if (host_nvm_addr >= trim_cfg_pkg::NVM_BOOT_LO &&
			host_nvm_addr <= trim_cfg_pkg::NVM_BOOT_HI)
			addr_locked = lock[trim_cfg_pkg::LOCK_BOOT];
		else if (host_nvm_addr >= trim_cfg_pkg::NVM_FACTORY_LO &&
			host_nvm_addr <= trim_cfg_pkg::NVM_FACTORY_HI)
			addr_locked = lock[trim_cfg_pkg::LOCK_FACTORY];
		else if (host_nvm_addr >= trim_cfg_pkg::NVM_FIELDE_LO &&
			host_nvm_addr <= trim_cfg_pkg::NVM_FIELDE_HI)
			addr_locked = lock[trim_cfg_pkg::LOCK_REGION_E];
	end

	assign nvm_wr_grant   = host_nvm_req && !addr_locked;
	assign nvm_wr_refused = host_nvm_req && addr_locked;

	// monitor five routing
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			monitor_five_ov <= 1'b0;
			soft_overtemp   <= 1'b0;
		end
		else
		begin
			monitor_five_ov <= m5ov_s &&
				!cfg_r[5][trim_cfg_pkg::OT_SOFT_BIT];
			soft_overtemp   <= m5ov_s &&
				cfg_r[5][trim_cfg_pkg::OT_SOFT_BIT];
		end
	end

	// power-on source
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			pson_selected <= 1'b0;
		else if (cfg_r[7][trim_cfg_pkg::CFG_PSON_SRC])
			pson_selected <= sw_pson_bit;
		else
			pson_selected <= internal_pson;
	end

	// blanking hold start
	assign remap = cfg_r[7][trim_cfg_pkg::CFG_PIN_REMAP];

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mgood_d_r <= 1'b0;
			scl_d_r   <= 1'b1;
		end
		else
		begin
			mgood_d_r <= mgood_s;
			scl_d_r   <= scl_s;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			blank_hold_start <= 1'b0;
		else if (cfg_r[7][trim_cfg_pkg::CFG_UVB_MODE])
			blank_hold_start <= mgood_s && !mgood_d_r;
		else
			blank_hold_start <= remap && !scl_s && scl_d_r;
	end

	// monitor 1
	assign mon.func_sel  = cfg_r[7][trim_cfg_pkg::CFG_MON1_HI:
		trim_cfg_pkg::CFG_MON1_LO];
	assign mon.above_115 = a115_s;
	assign mon.above_125 = a125_s;
	assign mon.above_135 = a135_s;
	assign mon.sense_one = sense_s;

	mon1_decode u_mon1
	(
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.mon     (mon.decoder)
	);

	assign monitor1_flag = mon.flag;
	assign monitor1_ov   = mon.ov;
	assign monitor1_uv   = mon.uv;

	// serial pin roles
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			scl_out <= 1'b0;
			scl_oe  <= 1'b0;
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end
		else if (remap)
		begin
			scl_out <= mains_good_link;
			scl_oe  <= 1'b1;
			sda_out <= pson_link;
			sda_oe  <= 1'b1;
		end
		else
		begin
			scl_out <= 1'b0;
			scl_oe  <= smb_scl_pull;
			sda_out <= 1'b0;
			sda_oe  <= smb_sda_pull;
		end
	end

	assign smb_scl_in = remap ? 1'b1 : scl_s;
	assign smb_sda_in = remap ? 1'b1 : sda_s;

endmodule : psu_trim_config_registers

// [bench/nvm_boot_model.sv]
// nonvolatile boot memory model answering the boot reads
`timescale 1ns/100ps
module nvm_boot_model
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// boot read port
	input  wire logic        nvm_rd_req,
	input  wire logic [15:0] nvm_rd_addr,
	output logic             nvm_rd_valid,
	output logic [7:0]       nvm_rd_data
);
	logic [15:0] addr_r;
	logic [2:0]  wait_r;
	logic        slow_r;

	// alternates prompt and slow answers, data scrambled off-answer
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			addr_r       <= 16'h0000;
			wait_r       <= 3'h0;
			slow_r       <= 1'b0;
			nvm_rd_valid <= 1'b0;
			nvm_rd_data  <= 8'h00;
		end
		else
		begin
			nvm_rd_valid <= 1'b0;
			nvm_rd_data  <= ~nvm_rd_data;
			if (nvm_rd_req)
			begin
				addr_r <= nvm_rd_addr;
				wait_r <= slow_r ? 3'h4 : 3'h1;
				slow_r <= ~slow_r;
			end
			else if (wait_r != 3'h0)
			begin
				wait_r <= wait_r - 3'h1;
				if (wait_r == 3'h1)
				begin
					nvm_rd_valid <= 1'b1;
					nvm_rd_data  <= addr_r[7:0] ^ 8'hc3;
				end
			end
		end
	end
endmodule : nvm_boot_model

// [bench/psu_trim_config_registers_checker.sv]
// port assertions for the trim and configuration register bank
`timescale 1ns/100ps
module psu_trim_config_registers_checker
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// register port
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        boot_done,
	// boot and filter
	input wire logic        nvm_rd_req,
	input wire logic [15:0] nvm_rd_addr,
	input wire logic        host_nvm_req,
	input wire logic [15:0] host_nvm_addr,
	input wire logic        nvm_wr_grant,
	input wire logic        nvm_wr_refused,
	// trims and monitors
	input wire logic [6:0]  share_slope_trim,
	input wire logic [7:0]  remote_overvolt_trim,
	input wire logic [3:0]  overtemp_trim,
	input wire logic [4:0]  mains_thresh_trim,
	input wire logic [2:0]  mains_hyst_trim,
	input wire logic        monitor_five_ov,
	input wire logic        soft_overtemp,
	input wire logic        monitor1_ov,
	input wire logic        monitor1_uv
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_wr(logic [7:0] a);
		reg_wr && boot_done && reg_addr == a;
	endsequence

	property p_slope;
		s_wr(8'h06) |=> share_slope_trim == $past(reg_wdata[7:1]);
	endproperty
	property p_trim;
		s_wr(8'h08) |=> remote_overvolt_trim == $past(reg_wdata);
	endproperty
	property p_ot;
		s_wr(8'h0b) |=> overtemp_trim == $past(reg_wdata[7:4]);
	endproperty
	property p_mains;
		s_wr(8'h0c) |=>
			{mains_thresh_trim, mains_hyst_trim} == $past(reg_wdata);
	endproperty
	property p_boot_addr;
		nvm_rd_req |-> nvm_rd_addr >= 16'h8106 && nvm_rd_addr <= 16'h810d;
	endproperty
	property p_filter;
		(nvm_wr_grant || nvm_wr_refused) == host_nvm_req
			&& !(nvm_wr_grant && nvm_wr_refused);
	endproperty
	property p_open;
		host_nvm_req && host_nvm_addr > 16'h817f |-> nvm_wr_grant;
	endproperty
	property p_monitor_five;
		!(monitor_five_ov && soft_overtemp);
	endproperty
	property p_mon1;
		!(monitor1_ov && monitor1_uv);
	endproperty

	a_slope: assert property (p_slope) else $error("slope trim");
	a_trim: assert property (p_trim) else $error("ov trim");
	a_ot: assert property (p_ot) else $error("ot trim");
	a_mains: assert property (p_mains) else $error("mains trim");
	a_boot_addr: assert property (p_boot_addr) else $error("boot");
	a_filter: assert property (p_filter) else $error("filter");
	a_open: assert property (p_open) else $error("open area");
	a_monitor_five: assert property (p_monitor_five) else $error("monitor_five route");
	a_mon1: assert property (p_mon1) else $error("mon1 ov uv");
endmodule : psu_trim_config_registers_checker

bind psu_trim_config_registers psu_trim_config_registers_checker chk (
	.sys_clk, .nrst, .reg_wr, .reg_addr, .reg_wdata, .boot_done,
	.nvm_rd_req, .nvm_rd_addr, .host_nvm_req, .host_nvm_addr,
	.nvm_wr_grant, .nvm_wr_refused, .share_slope_trim,
	.remote_overvolt_trim, .overtemp_trim, .mains_thresh_trim,
	.mains_hyst_trim, .monitor_five_ov, .soft_overtemp, .monitor1_ov,
	.monitor1_uv);

// [bench/psu_trim_config_registers_bench.sv]
// testbench for the trim and configuration register bank
`timescale 1ns/100ps
module psu_trim_config_registers_bench;
	logic sys_clk, nrst, reg_wr, reg_rd, reg_hit, nvm_rd_req, nvm_rd_valid;
	logic boot_done, host_nvm_req, nvm_wr_grant, nvm_wr_refused;
	logic monitor_five_ov_pin, monitor_five_ov, soft_overtemp;
	logic internal_pson, sw_pson_bit, pson_selected;
	logic mains_good_pin, blank_hold_start, mains_sense_one_input;
	logic mon1_above_115_pin, mon1_above_125_pin, mon1_above_135_pin;
	logic monitor1_flag, monitor1_ov, monitor1_uv;
	logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
	logic smb_scl_pull, smb_sda_pull, smb_scl_in, smb_sda_in;
	logic mains_good_link, pson_link;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, nvm_rd_data, a;
	logic [15:0] nvm_rd_addr, host_nvm_addr;
	logic [6:0]  share_slope_trim;
	logic [7:0]  remote_overvolt_trim, local_undervolt_trim;
	logic [7:0]  local_overvolt_trim;
	logic [3:0]  overtemp_trim;
	logic [4:0]  mains_thresh_trim;
	logic [2:0]  mains_hyst_trim, mode;
	int n_errors, check_count, i;
	logic [7:0] mask [8] = '{8'hfe, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hf1,
		8'hff, 8'h9f};
	logic [7:0] lo_t [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00,
		8'h00, 8'h04};
	logic [7:0] hi_t [8] = '{8'h04, 8'h04, 8'h06, 8'h04, 8'h04, 8'h05,
		8'h04, 8'h00};
	logic [15:0] base [7] = '{16'h8000, 16'h8040, 16'h8080, 16'h80c0,
		16'h8100, 16'h8120, 16'h8140};

	// pins pulled up when not driven
	assign scl_in = scl_oe ? scl_out : 1'b1;
	assign sda_in = sda_oe ? sda_out : 1'b1;

	psu_trim_config_registers DUT (.sys_clk, .nrst, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .nvm_rd_req,
		.nvm_rd_addr, .nvm_rd_valid, .nvm_rd_data, .boot_done,
		.host_nvm_req, .host_nvm_addr, .nvm_wr_grant, .nvm_wr_refused,
		.share_slope_trim, .remote_overvolt_trim, .local_undervolt_trim,
		.local_overvolt_trim, .overtemp_trim, .mains_thresh_trim,
		.mains_hyst_trim, .monitor_five_ov_pin, .monitor_five_ov,
		.soft_overtemp, .internal_pson, .sw_pson_bit, .pson_selected,
		.mains_good_pin, .blank_hold_start, .mon1_above_115_pin,
		.mon1_above_125_pin, .mon1_above_135_pin, .mains_sense_one_input,
		.monitor1_flag, .monitor1_ov, .monitor1_uv, .scl_in, .scl_out,
		.scl_oe, .sda_in, .sda_out, .sda_oe, .smb_scl_pull, .smb_sda_pull,
		.smb_scl_in, .smb_sda_in, .mains_good_link, .pson_link);

	nvm_boot_model mem (.sys_clk, .nrst, .nvm_rd_req, .nvm_rd_addr,
		.nvm_rd_valid, .nvm_rd_data);

	task automatic complete_run;
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] want);
		check_count++;
		if (seen !== want)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(negedge sys_clk);
		reg_wr = 1'b1;
		reg_addr = ad;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [7:0] want);
		@(negedge sys_clk);
		reg_rd = 1'b1;
		reg_addr = ad;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		check("read data", reg_rdata, want);
		check("hit", {7'h0, reg_hit}, {7'h0, ad >= 8'h06 && ad <= 8'h0d});
	endtask : rd

	task automatic wait_blank;
		int k;
		for (k = 0; k < 12 && blank_hold_start !== 1'b1; k++)
			@(negedge sys_clk);
		check("blank start", {7'h0, blank_hold_start}, 8'h01);
		if (blank_hold_start !== 1'b1)
			complete_run;
	endtask : wait_blank

	task automatic set_mon(input logic v);
		{mon1_above_115_pin, mon1_above_125_pin} = {v, v};
		{mon1_above_135_pin, mains_sense_one_input} = {v, v};
		cyc(5);
	endtask : set_mon

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial
	begin
		{nrst, reg_wr, reg_rd, host_nvm_req, monitor_five_ov_pin} = 5'h00;
		{internal_pson, sw_pson_bit, mains_good_pin} = 3'h0;
		{smb_scl_pull, smb_sda_pull, pson_link} = 3'h1;
		mains_good_link = 1'b1;
		{reg_addr, reg_wdata, host_nvm_addr} = 32'h0000_0000;
		n_errors = 0;
		check_count = 0;
		set_mon(1'b0);
		cyc(11);
		nrst = 1'b1;
		for (i = 0; i < 400 && boot_done !== 1'b1; i++)
			cyc(1);
		if (i == 400)
		begin
			n_errors++;
			complete_run;
		end
		// boot image, then each register written full and empty
		for (i = 0; i < 8; i++)
		begin
			a = 8'h06 + 8'(i);
			rd(a, (a ^ 8'hc3) & mask[i]);
			wr(a, 8'hff);
			rd(a, mask[i]);
			wr(a, 8'h00);
			rd(a, 8'h00);
		end
		wr(8'h09, 8'h5a);
		wr(8'h0a, 8'ha5);
		check("uv trim", local_undervolt_trim, 8'h5a);
		check("ov trim", local_overvolt_trim, 8'ha5);
		rd(8'h05, 8'h00);
		rd(8'h0e, 8'h00);
		// each lock bit guards its region only
		host_nvm_req = 1'b1;
		for (i = 0; i < 7; i++)
		begin
			wr(8'h07, 8'h01 << i);
			host_nvm_addr = base[i] + 16'h001f;
			cyc(1);
			check("refused", {7'h0, nvm_wr_refused}, 8'h01);
			host_nvm_addr = base[(i + 1) % 7];
			cyc(1);
			check("granted", {7'h0, nvm_wr_grant}, 8'h01);
		end
		wr(8'h07, 8'h7f);
		host_nvm_addr = 16'h8180;
		cyc(1);
		check("open", {7'h0, nvm_wr_grant}, 8'h01);
		host_nvm_req = 1'b0;
		// monitor five routing and power-on source
		monitor_five_ov_pin = 1'b1;
		internal_pson = 1'b1;
		wr(8'h0b, 8'h00);
		cyc(4);
		check("monitor_five", {6'h0, monitor_five_ov, soft_overtemp}, 8'h02);
		wr(8'h0b, 8'h01);
		cyc(4);
		check("monitor_five", {6'h0, monitor_five_ov, soft_overtemp}, 8'h01);
		wr(8'h0d, 8'h00);
		cyc(2);
		check("pson", {7'h0, pson_selected}, 8'h01);
		wr(8'h0d, 8'h80);
		cyc(2);
		check("pson", {7'h0, pson_selected}, 8'h00);
		// every monitor-1 code below and above the thresholds
		for (i = 0; i < 8; i++)
		begin
			mode = 3'(i);
			wr(8'h0d, {4'h0, mode, 1'b0});
			set_mon(1'b0);
			a = {5'h0, monitor1_flag, monitor1_ov, monitor1_uv};
			check("mon1 low", a, lo_t[i]);
			set_mon(1'b1);
			a = {5'h0, monitor1_flag, monitor1_ov, monitor1_uv};
			check("mon1 high", a, hi_t[i]);
		end
		// hysteresis window of the upper threshold pair
		wr(8'h0d, 8'h06);
		mon1_above_135_pin = 1'b0;
		cyc(5);
		a = {5'h0, monitor1_flag, monitor1_ov, monitor1_uv};
		check("mon1 hold", a, 8'h04);
		mon1_above_125_pin = 1'b0;
		cyc(5);
		a = {5'h0, monitor1_flag, monitor1_ov, monitor1_uv};
		check("mon1 drop", a, 8'h01);
		// sense passthrough ignores the comparators
		wr(8'h0d, 8'h00);
		{mon1_above_125_pin, mon1_above_135_pin} = 2'h3;
		mains_sense_one_input = 1'b0;
		cyc(5);
		a = {5'h0, monitor1_flag, monitor1_ov, monitor1_uv};
		check("mon1 sense", a, 8'h00);
		// blanking starts and serial pin remap
		wr(8'h0d, 8'h10);
		cyc(4);
		mains_good_pin = 1'b1;
		wait_blank;
		wr(8'h0d, 8'h01);
		pson_link = 1'b0;
		cyc(4);
		a = {4'h0, scl_oe, sda_oe, smb_scl_in, smb_sda_in};
		check("remap", a, 8'h0f);
		check("links", {6'h0, scl_out, sda_out}, 8'h02);
		mains_good_link = 1'b0;
		wait_blank;
		// plain serial pins follow the engine pulls
		wr(8'h0d, 8'h00);
		smb_scl_pull = 1'b1;
		cyc(4);
		a = {4'h0, scl_oe, sda_oe, smb_scl_in, smb_sda_in};
		check("smb pins", a, 8'h09);
		complete_run;
	end
endmodule : psu_trim_config_registers_bench
